// ---- hw/see_pkg.sv ----
// Package for the serial EEPROM command port: types, timing and encodings
package see_pkg;
  // Clock and programming timing
  localparam int CLK_HZ = 20000000;
  localparam int PROG_TIME_MAX_MS = 10;
  localparam int PROG_TIME_TYP_MS = 4;
  localparam int PROG_CYCLES = (CLK_HZ / 1000) * PROG_TIME_TYP_MS;
  localparam int PROG_MAX_CYCLES = (CLK_HZ / 1000) * PROG_TIME_MAX_MS;
  // Word geometry
  localparam int WORD_W = 16;
  localparam int ADDR_W_SMALL = 6;
  localparam int ADDR_W_LARGE = 8;
  localparam int DEPTH_DEFAULT = 64;
  localparam int FIFO_DEPTH = 16;
  // Opcode encodings
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_DIS = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL_WORDS = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL_WORDS = 2'h2;
  localparam logic [1:0] EXT_EN = 2'h3;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;

  typedef enum logic [2:0] {
    SEE_IDLE, SEE_OPC, SEE_ADDR, SEE_DATA, SEE_READ, SEE_SKIP
  } see_phase_e;

  typedef enum logic [1:0] {
    SEE_PG_NONE, SEE_PG_ONE, SEE_PG_ALL
  } see_prog_e;

  // Programming request handed from the shifter to the array
  typedef struct packed {
    see_prog_e kind;
    logic [ADDR_W_LARGE-1:0] addr;
    logic [WORD_W-1:0] data;
  } see_req_s;
endpackage : see_pkg

// ---- hw/see_port.sv ----
// Serial EEPROM command port: FIFO and command-port top
`timescale 1ns/1ps

// Synchronous FIFO with valid/ready on both sides
module see_fifo
  import see_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } see_fifo_s;
  see_fifo_s st_reg;
  see_fifo_s st_next;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic push;
  logic pop;

  // Handshakes from honest full and empty
  assign in_ready = (st_reg.cnt != (PW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_reg[st_reg.rp];

  // Pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push) st_next.wp = PW'(st_reg.wp + 1'b1);
    if (pop) st_next.rp = PW'(st_reg.rp + 1'b1);
    st_next.cnt = (PW+1)'(st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) st_reg <= '0;
    else st_reg <= st_next;
  end

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem_reg[st_reg.wp] <= in_data;
  end
endmodule : see_fifo

// Device-side serial command decoder, array and self-timed programmer
module see_port
  import see_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT,
  parameter int ADDR_W = ADDR_W_SMALL,
  parameter int PROG_CNT = PROG_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic busy
);
// Behaviour
// - Sample data in on each rising serial clock while selected, in order.
// - Start bit is a sampled high; low-sampled dummy clocks are ignored.
// - Falling chip select ends instruction input; host waits deselect interval.
// - While deselected the device idles and ignores clock and data.
// - After last read address bit, drive output low then shift word out.
// - Continued clocks after the last bit output the next word.
// - Sequential read address wraps from top word to zero.
// - Programming commands start self-timed programming on chip select fall.
// - Programming completes within 10 ms, typical under 5 ms.
// - Selected during programming, output low while busy, high when done.
// - Clock and data are ignored during programming.
// - A start bit while showing ready returns output to high impedance.
// - Write data keeps only the last 16 bits received.
// - Writes program the word directly without prior erase.
// - Erase sets every bit of the addressed word to one.
// - Write-all programs the received word into every address.
// - Erase-all sets every bit of every word to one.
// - Enable command sets the write-enable latch allowing programming.
// - Disable command clears the latch, refusing programming commands.
// - Write-enable latch is clear after power-up.
// - Opcodes 10 read, 01 write, 11 erase, 00 extended by address top.
// - Sixty-four to 256 words of 16 bits; address 6 or 8 bits.

  localparam int CW = $clog2(PROG_CNT + 1);
  localparam int BW = $clog2(WORD_W + ADDR_W + 1);

  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sk_sync;
    logic [1:0] di_sync;
    logic sk_last;
    logic cs_last;
    see_phase_e phase;
    logic [1:0] opc;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] shreg;
    logic [BW-1:0] bits;
    logic data_seen;
    logic wen;
    logic prog;
    see_prog_e pkind;
    logic [ADDR_W-1:0] paddr;
    logic [WORD_W-1:0] pdata;
    logic [CW-1:0] pcnt;
    logic [ADDR_W-1:0] fill;
    logic ready_shown;
    logic dout;
    logic doe;
  } see_state_s;

  see_state_s st_reg;
  see_state_s st_next;
  logic [WORD_W-1:0] mem_reg [DEPTH];
  logic cs;
  logic sk_rise;
  logic di;
  logic cs_fall;
  see_req_s req_in;
  see_req_s req_out;
  logic req_valid;
  logic req_ready;
  logic req_take;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [WORD_W-1:0] mem_wd;

  // Address increment with wrap at the top word
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
    if (32'(a) >= DEPTH - 1) next_addr = '0;
    else next_addr = ADDR_W'(a + 1'b1);
  endfunction : next_addr

  // fold the address field onto the words that exist
  function automatic logic [ADDR_W-1:0] word_at(input logic [ADDR_W-1:0] a);
    word_at = ADDR_W'(32'(a) % DEPTH);
  endfunction : word_at

  // Synchronised pin views
  assign cs = st_reg.cs_sync[1];
  assign di = st_reg.di_sync[1];
  assign sk_rise = st_reg.sk_sync[1] & ~st_reg.sk_last;
  assign cs_fall = st_reg.cs_last & ~cs;

  // Requests queue between decoder and programmer
  assign req_take = req_valid & ~st_reg.prog;

  // Array write port driven by the programmer
  assign mem_we = st_reg.prog && (st_reg.pcnt == CW'(1));
  assign mem_wa = st_reg.fill;
  assign mem_wd = st_reg.pdata;

  see_fifo #(
    .WIDTH($bits(see_req_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_req_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_data(req_in),
    .in_valid(cs_fall && st_reg.phase == SEE_DATA
              || cs_fall && st_reg.phase == SEE_SKIP && st_reg.data_seen),
    .in_ready(req_ready),
    .out_data(req_out),
    .out_valid(req_valid),
    .out_ready(req_take)
  );

  // Request built from the finished instruction
  always_comb begin
    req_in.kind = SEE_PG_ONE;
    req_in.addr = ADDR_W_LARGE'(st_reg.addr);
    req_in.data = st_reg.shreg;
    if (st_reg.opc == OP_ERASE) req_in.data = ERASED_WORD;
    if (st_reg.opc == OP_EXT) req_in.kind = SEE_PG_ALL;
  end

  // Decoder and programmer next state
  always_comb begin
    st_next = st_reg;
    st_next.cs_sync = {st_reg.cs_sync[0], chip_select};
    st_next.sk_sync = {st_reg.sk_sync[0], serial_clock_in};
    st_next.di_sync = {st_reg.di_sync[0], serial_data_in};
    st_next.sk_last = st_reg.sk_sync[1];
    st_next.cs_last = cs;
    if (!cs) begin
      st_next.phase = SEE_IDLE;
      st_next.bits = '0;
      st_next.data_seen = 1'b0;
      st_next.doe = 1'b0;
      st_next.ready_shown = 1'b0;
    end else if (st_reg.prog || req_valid) begin
      st_next.doe = 1'b1;
      st_next.dout = 1'b0;
    end else if (sk_rise) begin
      case (st_reg.phase)
        SEE_IDLE: begin
          if (di) begin
            st_next.phase = SEE_OPC;
            st_next.bits = '0;
            st_next.doe = 1'b0;
          end
        end
        SEE_OPC: begin
          st_next.opc = {st_reg.opc[0], di};
          st_next.bits = BW'(st_reg.bits + 1'b1);
          if (st_reg.bits == BW'(1)) begin
            st_next.phase = SEE_ADDR;
            st_next.bits = '0;
          end
        end
        SEE_ADDR: begin
          st_next.addr = {st_reg.addr[ADDR_W-2:0], di};
          st_next.bits = BW'(st_reg.bits + 1'b1);
          if (st_reg.bits == BW'(ADDR_W - 1)) begin
            st_next.bits = '0;
            st_next.phase = SEE_SKIP;
            if (st_reg.opc == OP_READ) begin
              st_next.phase = SEE_READ;
              st_next.doe = 1'b1;
              st_next.dout = 1'b0;
              st_next.addr = word_at({st_reg.addr[ADDR_W-2:0], di});
              st_next.shreg = mem_reg[word_at({st_reg.addr[ADDR_W-2:0], di})];
            end else if (st_reg.opc == OP_EXT) begin
              if (st_reg.addr[ADDR_W-2] == EXT_EN[1] &&
                  st_reg.addr[ADDR_W-3] == EXT_EN[0])
                st_next.wen = 1'b1;
              else if (st_reg.addr[ADDR_W-2:ADDR_W-3] == EXT_DIS)
                st_next.wen = 1'b0;
              else if (st_reg.wen &&
                       st_reg.addr[ADDR_W-2:ADDR_W-3] == EXT_WRITE_ALL_WORDS)
                st_next.phase = SEE_DATA;
              else if (st_reg.wen &&
                       st_reg.addr[ADDR_W-2:ADDR_W-3] == EXT_ERASE_ALL_WORDS) begin
                st_next.shreg = ERASED_WORD;
                st_next.data_seen = 1'b1;
              end
            end else if (st_reg.wen) begin
              st_next.phase = (st_reg.opc == OP_WRITE) ? SEE_DATA : SEE_SKIP;
              st_next.data_seen = (st_reg.opc == OP_ERASE);
            end
          end
        end
        SEE_DATA: begin
          st_next.shreg = {st_reg.shreg[WORD_W-2:0], di};
          st_next.bits = BW'(st_reg.bits + 1'b1);
        end
        SEE_READ: begin
          st_next.dout = st_reg.shreg[WORD_W-1];
          st_next.shreg = {st_reg.shreg[WORD_W-2:0], 1'b0};
          st_next.bits = BW'(st_reg.bits + 1'b1);
          if (st_reg.bits == BW'(WORD_W - 1)) begin
            st_next.bits = '0;
            st_next.addr = next_addr(st_reg.addr);
            st_next.shreg = mem_reg[next_addr(st_reg.addr)];
          end
        end
        default: begin
        end
      endcase
    end else if (!st_reg.ready_shown && st_reg.phase == SEE_IDLE &&
                 st_reg.pcnt != '0) begin
      st_next.doe = 1'b1;
      st_next.dout = 1'b1;
      st_next.ready_shown = 1'b1;
    end
    if (req_take) begin
      st_next.prog = 1'b1;
      st_next.pkind = req_out.kind;
      st_next.paddr = ADDR_W'(req_out.addr);
      st_next.pdata = req_out.data;
      st_next.fill = (req_out.kind == SEE_PG_ALL) ? '0 :
                     word_at(ADDR_W'(req_out.addr));
      st_next.pcnt = CW'(PROG_CNT);
    end else if (st_reg.prog) begin
      st_next.pcnt = CW'(st_reg.pcnt - 1'b1);
      if (st_reg.pcnt == CW'(1)) begin
        if (st_reg.pkind == SEE_PG_ALL && 32'(st_reg.fill) < DEPTH - 1) begin
          st_next.fill = ADDR_W'(st_reg.fill + 1'b1);
          st_next.pcnt = CW'(1);
        end else begin
          st_next.prog = 1'b0;
          st_next.pcnt = CW'(1);
        end
      end
    end
  end

  // State register; write latch clear at power-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) mem_reg[mem_wa] <= mem_wd;
  end

  // Data and enable pins from flip-flops; busy decoded from programmer and queue state
  assign serial_data_out = st_reg.dout;
  assign serial_data_oe = st_reg.doe;
  assign busy = st_reg.prog | req_valid | ~req_ready;
endmodule : see_port

// ---- verif/see_host.sv ----
// Host model driving the serial pins of the command port
`timescale 1ns/1ps
module see_host (
  input wire logic clk,
  output logic chip_select,
  output logic serial_clock_in,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  // Idle pins: deselected, clock parked low
  initial begin
    chip_select = 1'b0;
    serial_clock_in = 1'b0;
    serial_data_in = 1'b0;
  end
  // data set up, then clock high; returns {oe, level} before rise
  task automatic bit_io(input logic d, output logic [1:0] q);
    serial_data_in <= d;
    repeat (4) @(posedge clk);
    q = {serial_data_oe, serial_data_out};
    serial_clock_in <= 1'b1;
    repeat (4) @(posedge clk);
    serial_clock_in <= 1'b0;
  endtask : bit_io
  // select, dummy clocks, then n bits MSB first
  task automatic send(input int nd, input logic [31:0] v, input int n);
    logic [1:0] q;
    chip_select <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < nd; i++) bit_io(1'b0, q);
    for (int i = n - 1; i >= 0; i--) bit_io(v[i], q);
  endtask : send
  // end the instruction and hold the deselect gap
  task automatic deselect();
    chip_select <= 1'b0;
    serial_data_in <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : deselect
  // select with data low, wait for the ready level
  task automatic poll(output logic [1:0] q0, output int n);
    chip_select <= 1'b1;
    serial_data_in <= 1'b0;
    repeat (8) @(posedge clk);
    q0 = {serial_data_oe, serial_data_out};
    n = 0;
    while ({serial_data_oe, serial_data_out} !== 2'b11 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask : poll
endmodule : see_host

// ---- verif/see_port_checker.sv ----
// Pin-level assertions for the command port
`timescale 1ns/1ps
module see_port_checker #(
  parameter int PROG_CNT = 20
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic busy
);
  int busy_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Length of the running busy spell
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) busy_reg <= 0;
    else busy_reg <= busy ? busy_reg + 1 : 0;
  end
  oe_standby_a: assert property (
    !chip_select [*5] |-> !serial_data_oe) else $error("driven while idle");
  busy_low_a: assert property (
    (busy && chip_select) [*5] |-> serial_data_oe && !serial_data_out)
    else $error("no busy level");
  ready_high_a: assert property (
    $fell(busy) && chip_select |-> ##[0:4] serial_data_oe && serial_data_out)
    else $error("no ready level");
  prog_min_a: assert property (
    $fell(busy) |-> busy_reg >= PROG_CNT) else $error("program too short");
  prog_max_a: assert property (
    busy_reg <= PROG_CNT + 80) else $error("program too long");
  busy_start_a: assert property (
    $rose(busy) |-> !chip_select) else $error("program began selected");
  start_drop_a: assert property (
    $rose(serial_clock_in) && serial_data_in && chip_select && serial_data_oe
    && serial_data_out |-> ##[1:6] !serial_data_oe) else $error("no release");
  oe_select_a: assert property (
    $rose(serial_data_oe) |-> chip_select) else $error("drive unselected");
endmodule : see_port_checker
bind see_port see_port_checker #(.PROG_CNT(PROG_CNT)) i_see_port_checker (
  .clk, .nrst, .chip_select, .serial_clock_in, .serial_data_in,
  .serial_data_out, .serial_data_oe, .busy);

// ---- verif/tb.sv ----
// Self-checking bench for the command port and its FIFO
`timescale 1ns/1ps
module tb;
  import see_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic chip_select, serial_clock_in, serial_data_in;
  logic serial_data_out, serial_data_oe, busy;
  logic [15:0] mem [64];
  logic [1:0] q;
  logic [31:0] r;
  int failures = 0;
  int checked = 0;
  int seed = 32'h17d7ded8;
  int w;
  bit wel = 1'b0;
  always #25 clk = ~clk;
  see_port #(.PROG_CNT(200)) i_see_port (.clk, .nrst, .chip_select,
    .serial_clock_in, .serial_data_in, .serial_data_out, .serial_data_oe,
    .busy);
  see_host i_see_host (.clk, .chip_select, .serial_clock_in,
    .serial_data_in, .serial_data_out, .serial_data_oe);
  // Compare a data word, then the {oe, level} pin pair
  task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %0t word %h expected %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_pin(input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %0t pins %b expected %b", $time, g, e);
    end
  endtask : chk_pin
  // One instruction; the model tracks the array and the latch
  task automatic prog(input logic [1:0] op, input logic [5:0] a,
      input logic [15:0] d, input bit inj);
    bit ext, pg, era;
    ext = op == OP_EXT;
    era = op == OP_ERASE || (ext && a[5:4] == EXT_ERASE_ALL_WORDS);
    pg = op == OP_WRITE || op == OP_ERASE || (ext && a[5] != a[4]);
    r = $random(seed);
    // dummy clocks and a spare leading data bit
    if (op == OP_WRITE || (ext && a[5:4] == EXT_WRITE_ALL_WORDS))
      i_see_host.send(2, {6'h0, 1'b1, op, a, r[0], d}, 26);
    else
      i_see_host.send(0, {23'h0, 1'b1, op, a}, 9);
    i_see_host.deselect();
    chk_pin({1'b0, pg && wel}, {1'b0, busy});
    if (pg && wel) begin
      // an instruction sent while busy must be dropped
      if (inj) i_see_host.send(0, {23'h0, 1'b1, OP_EXT, EXT_DIS, 4'h0}, 9);
      if (inj) i_see_host.deselect();
      for (int i = 0; i < 64; i++)
        if (ext || i == a) mem[i] = era ? ERASED_WORD : d;
      i_see_host.poll(q, w);
      chk_pin(2'b10, q);
      chk_pin(2'b11, {serial_data_oe, serial_data_out});
    end
    if (ext && a[5:4] == EXT_EN) wel = 1'b1;
    if (ext && a[5:4] == EXT_DIS) wel = 1'b0;
  endtask : prog
  // Sequential read of n words from address a
  task automatic rd(input int a, input int n);
    logic [15:0] g;
    i_see_host.send(0, {23'h0, 1'b1, OP_READ, 6'(a)}, 9);
    i_see_host.bit_io(1'b0, q);
    chk_pin(2'b10, q);
    for (int k = 0; k < n; k++) begin
      for (int b = 15; b >= 0; b--) begin
        i_see_host.bit_io(1'b0, q);
        g[b] = q[0];
      end
      chk_word(mem[(a + k) % 64], g);
    end
    i_see_host.deselect();
  endtask : rd
  // Random requests through the design's queue, each read back at once
  task automatic fifo_run();
    int a;
    prog(OP_EXT, {EXT_EN, 4'h0}, 16'h0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      a = r[21:16];
      prog(OP_WRITE, r[21:16], r[15:0], r[22]);
      rd(a, 2);
    end
    prog(OP_EXT, {EXT_DIS, 4'h0}, 16'h0, 1'b0);
  endtask : fifo_run
  // Print the verdict and stop
  task automatic conclude();
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    prog(OP_WRITE, 6'h05, 16'h1234, 1'b0);
    prog(OP_EXT, {EXT_EN, 4'h0}, 16'h0, 1'b0);
    prog(OP_EXT, {EXT_ERASE_ALL_WORDS, 4'h5}, 16'h0, 1'b0);
    rd(62, 3);
    prog(OP_EXT, {EXT_WRITE_ALL_WORDS, r[3:0]}, r[31:16], 1'b1);
    rd(0, 2);
    for (int i = 0; i < 4; i++) prog(OP_WRITE, 6'(62 + i), r[15:0], 1'b0);
    prog(OP_ERASE, 6'h3f, 16'h0, 1'b0);
    rd(61, 5);
    // back to write-disabled, then a refused erase
    prog(OP_EXT, {EXT_DIS, 4'h0}, 16'h0, 1'b0);
    prog(OP_ERASE, 6'h00, 16'h0, 1'b0);
    rd(63, 2);
    fifo_run();
    conclude();
  end
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule : tb
